/* core/uic_defs.svh */
// offsets, field positions, reset values and fixed codes of the serial port register slice
`ifndef UIC_DEFS_SVH
`define UIC_DEFS_SVH

// register byte offsets
`define UIC_OFS_IRQ_ENABLE   12'h038
`define UIC_OFS_IRQ_RAW      12'h03C
`define UIC_OFS_IRQ_MASKED   12'h040
`define UIC_OFS_IRQ_CLEAR    12'h044
`define UIC_OFS_IDENT_FOUR   12'hFD0
`define UIC_OFS_IDENT_FIVE   12'hFD4
`define UIC_OFS_IDENT_SIX    12'hFD8

// interrupt source field positions within a register word
`define UIC_BIT_RX           4
`define UIC_BIT_TX           5
`define UIC_BIT_RX_TIMEOUT   6
`define UIC_BIT_FRAMING      7
`define UIC_BIT_PARITY       8
`define UIC_BIT_BREAK        9
`define UIC_SRC_LO           4
`define UIC_SRC_HI           9
`define UIC_SRC_N            6

// reset values, and the fixed value read back from the clear register
`define UIC_ENABLE_RST       6'h00
`define UIC_RAW_RST          6'h00
`define UIC_CLEAR_READ       32'h00000000

// identification field defaults, values are arbitrary
`define UIC_IDENT_FOUR_DEF   8'h3C
`define UIC_IDENT_FIVE_DEF   8'h5E
`define UIC_IDENT_SIX_DEF    8'h71

// bus responses
`define UIC_RESP_OKAY        2'h0
`define UIC_RESP_SLVERR      2'h2

`endif

/* core/uic_pkg.sv */
// types shared by the serial port register slice
`default_nettype none

package uic_pkg;

  typedef enum logic [2:0] {
    uic_sel_none   = 3'b000,
    uic_sel_enable = 3'b001,
    uic_sel_raw    = 3'b010,
    uic_sel_masked = 3'b011,
    uic_sel_clear  = 3'b100,
    uic_sel_id4    = 3'b101,
    uic_sel_id5    = 3'b110,
    uic_sel_id6    = 3'b111
  } uic_sel_t;

  typedef logic [5:0] uic_src_t;

endpackage

`default_nettype wire

/* core/uic_irq_status.sv */
// sticky raw interrupt latches with enable gating and level interrupt
`default_nettype none

module uic_irq_status #(
  parameter int N = 6
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // events and controls
  input  wire logic [N-1:0] set_vec,
  input  wire logic [N-1:0] clr_vec,
  input  wire logic [N-1:0] enable,
  // state
  output logic      [N-1:0] raw,
  output logic      [N-1:0] masked,
  output logic              irq
);

  logic [N-1:0] next_raw;

  // a set in the same cycle as its clear wins
  always_comb begin
    next_raw = (raw & ~clr_vec) | set_vec;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      raw <= '0;
    end else begin
      raw <= next_raw;
    end
  end

  // clearing raw also removes the masked view
  assign masked = raw & enable;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_raw & enable);
    end
  end

endmodule

`default_nettype wire

/* core/uic_regs.sv */
// axi4-lite register slice: interrupt clear, enable, status and identification bytes
//
// Added by the designer: the AXI4-Lite slave port.
`include "uic_defs.svh"
`default_nettype none

module uic_regs #(
  parameter int         ADDR_W      = 12,
  parameter logic [7:0] IDENT_FOUR  = `UIC_IDENT_FOUR_DEF,
  parameter logic [7:0] IDENT_FIVE  = `UIC_IDENT_FIVE_DEF,
  parameter logic [7:0] IDENT_SIX   = `UIC_IDENT_SIX_DEF
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rstn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // interrupt events from the serial unit, one-cycle pulses
  input  wire logic              evt_rx,
  input  wire logic              evt_tx,
  input  wire logic              evt_rx_timeout,
  input  wire logic              evt_framing_err,
  input  wire logic              evt_parity_err,
  input  wire logic              evt_break_err,
  // clear strobes to the serial unit, one-cycle pulses
  output logic                   rx_irq_clear,
  output logic                   tx_irq_clear,
  output logic                   rx_timeout_clear,
  output logic                   framing_err_clear,
  output logic                   parity_err_clear,
  output logic                   break_err_clear,
  // interrupt line
  output logic                   irq
);

  import uic_pkg::*;

  localparam int SLO = `UIC_SRC_LO;
  localparam int SHI = `UIC_SRC_HI;

  // address decode, shared by read and write paths
  function automatic uic_sel_t uic_decode(input logic [ADDR_W-1:0] addr);
    logic [11:0] ofs;
    ofs = addr[11:0];
    case (ofs)
      `UIC_OFS_IRQ_ENABLE: uic_decode = uic_sel_enable;
      `UIC_OFS_IRQ_RAW:    uic_decode = uic_sel_raw;
      `UIC_OFS_IRQ_MASKED: uic_decode = uic_sel_masked;
      `UIC_OFS_IRQ_CLEAR:  uic_decode = uic_sel_clear;
      `UIC_OFS_IDENT_FOUR: uic_decode = uic_sel_id4;
      `UIC_OFS_IDENT_FIVE: uic_decode = uic_sel_id5;
      `UIC_OFS_IDENT_SIX:  uic_decode = uic_sel_id6;
      default:             uic_decode = uic_sel_none;
    endcase
  endfunction

  // source field of a write word, gated by its byte strobes
  function automatic uic_src_t uic_src_field(input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    uic_src_field = uic_src_t'((data & lanes) >> SLO);
  endfunction

  // strobe mask over the source field
  function automatic uic_src_t uic_src_lanes(input logic [3:0] strb);
    uic_src_lanes = uic_src_field(32'hFFFFFFFF, strb);
  endfunction

  // place a source vector into its register position
  function automatic logic [31:0] uic_place(input uic_src_t v);
    uic_place = 32'(v) << SLO;
  endfunction

  // write channel holding
  logic              aw_held;
  logic [ADDR_W-1:0] aw_addr;
  logic              w_held;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_fire;
  uic_sel_t          wr_sel;

  // register state
  uic_src_t          enable;
  uic_src_t          raw;
  uic_src_t          masked;
  uic_src_t          set_vec;
  uic_src_t          clr_vec;
  logic              irq_int;

  // read path
  logic              rd_fire;
  uic_sel_t          rd_sel;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_sel  = uic_decode(aw_addr);
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_sel  = uic_decode(s_axi_araddr);

  // write address capture
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  // write data capture
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `UIC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (wr_sel == uic_sel_none) begin
        s_axi_bresp <= `UIC_RESP_SLVERR;
      end else begin
        s_axi_bresp <= `UIC_RESP_OKAY;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // enable register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      enable <= `UIC_ENABLE_RST;
    end else if (wr_fire && wr_sel == uic_sel_enable) begin
      enable <= (enable & ~uic_src_lanes(w_strb)) | uic_src_field(w_data, w_strb);
    end
  end

  // clear vector: only ones act, reserved bits 3:0 are dropped
  always_comb begin
    clr_vec = '0;
    if (wr_fire && wr_sel == uic_sel_clear) begin
      clr_vec = uic_src_field(w_data, w_strb);
    end
  end

  // event vector in field order
  always_comb begin
    set_vec = '0;
    set_vec[`UIC_BIT_RX - SLO]         = evt_rx;
    set_vec[`UIC_BIT_TX - SLO]         = evt_tx;
    set_vec[`UIC_BIT_RX_TIMEOUT - SLO] = evt_rx_timeout;
    set_vec[`UIC_BIT_FRAMING - SLO]    = evt_framing_err;
    set_vec[`UIC_BIT_PARITY - SLO]     = evt_parity_err;
    set_vec[`UIC_BIT_BREAK - SLO]      = evt_break_err;
  end

  uic_irq_status #(
    .N        (`UIC_SRC_N)
  ) u_status (
    .core_clk (core_clk),
    .rstn     (rstn),
    .set_vec  (set_vec),
    .clr_vec  (clr_vec),
    .enable   (enable),
    .raw      (raw),
    .masked   (masked),
    .irq      (irq_int)
  );

  assign irq = irq_int;

  // clear strobes to the serial unit
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_irq_clear      <= 1'b0;
      tx_irq_clear      <= 1'b0;
      rx_timeout_clear  <= 1'b0;
      framing_err_clear <= 1'b0;
      parity_err_clear  <= 1'b0;
      break_err_clear   <= 1'b0;
    end else begin
      rx_irq_clear      <= clr_vec[`UIC_BIT_RX - SLO];
      tx_irq_clear      <= clr_vec[`UIC_BIT_TX - SLO];
      rx_timeout_clear  <= clr_vec[`UIC_BIT_RX_TIMEOUT - SLO];
      framing_err_clear <= clr_vec[`UIC_BIT_FRAMING - SLO];
      parity_err_clear  <= clr_vec[`UIC_BIT_PARITY - SLO];
      break_err_clear   <= clr_vec[`UIC_BIT_BREAK - SLO];
    end
  end

  // read data select
  always_comb begin
    next_rdata = 32'h00000000;
    next_rresp = `UIC_RESP_OKAY;
    case (rd_sel)
      uic_sel_enable: next_rdata = uic_place(enable);
      uic_sel_raw:    next_rdata = uic_place(raw);
      uic_sel_masked: next_rdata = uic_place(masked);
      uic_sel_clear:  next_rdata = `UIC_CLEAR_READ;
      uic_sel_id4:    next_rdata = {24'h000000, IDENT_FOUR};
      uic_sel_id5:    next_rdata = {24'h000000, IDENT_FIVE};
      uic_sel_id6:    next_rdata = {24'h000000, IDENT_SIX};
      default:        next_rresp = `UIC_RESP_SLVERR;
    endcase
  end

  // read response
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `UIC_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* verif/uic_regs_props.sv */
// assertion checker for the serial port register slice
`include "uic_defs.svh"
`default_nettype none

module uic_regs_props (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rstn,
  // write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // read channels
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // clear strobes
  input wire logic        break_err_clear,
  input wire logic        rx_irq_clear
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr;
    !s_axi_bvalid && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  property p_brk_clr;
    break_err_clear |-> s_axi_bvalid && !$past(s_axi_bvalid);
  endproperty
  property p_rx_pulse;
    rx_irq_clear |=> !rx_irq_clear;
  endproperty
  property p_wr_ack;
    s_wr |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  property p_wr_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_rd_lat;
    s_rd |=> s_axi_rvalid;
  endproperty
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_rd_upper;
    s_axi_rvalid |-> s_axi_rdata[31:10] == 22'h0;
  endproperty
  property p_id_four;
    s_rd ##0 (s_axi_araddr == `UIC_OFS_IDENT_FOUR) |=>
      s_axi_rdata == {24'h0, `UIC_IDENT_FOUR_DEF};
  endproperty
  property p_id_five;
    s_rd ##0 (s_axi_araddr == `UIC_OFS_IDENT_FIVE) |=>
      s_axi_rdata == {24'h0, `UIC_IDENT_FIVE_DEF};
  endproperty
  property p_id_six;
    s_rd ##0 (s_axi_araddr == `UIC_OFS_IDENT_SIX) |=>
      s_axi_rdata == {24'h0, `UIC_IDENT_SIX_DEF};
  endproperty

  a_brk_clr: assert property (p_brk_clr) else $error("break strobe not after write");
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx clear strobe too long");
  a_wr_ack: assert property (p_wr_ack) else $error("write answer late");
  a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  a_rd_hold: assert property (p_rd_hold) else $error("read data changed");
  a_rd_upper: assert property (p_rd_upper) else $error("reserved read bits set");
  a_id_four: assert property (p_id_four) else $error("ident four wrong");
  a_id_five: assert property (p_id_five) else $error("ident five wrong");
  a_id_six: assert property (p_id_six) else $error("ident six wrong");
endmodule

bind uic_regs uic_regs_props uic_regs_props_i (.*);

`default_nettype wire

/* verif/uic_regs_tb.sv */
// self-checking bench for the serial port register slice
`include "uic_defs.svh"
`default_nettype none

module uic_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, c;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [5:0]  evt;
  wire  [5:0]  stb;
  logic [5:0]  stb_q [$];
  logic [11:0] ofs [7];
  logic [31:0] rv [7];
  int          errors, n_tests, seed, m_raw, m_en, i;

  uic_regs uic_regs_i (
    .core_clk(core_clk), .rstn(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .evt_rx(evt[0]), .evt_tx(evt[1]), .evt_rx_timeout(evt[2]),
    .evt_framing_err(evt[3]), .evt_parity_err(evt[4]), .evt_break_err(evt[5]),
    .rx_irq_clear(stb[0]), .tx_irq_clear(stb[1]), .rx_timeout_clear(stb[2]),
    .framing_err_clear(stb[3]), .parity_err_clear(stb[4]), .break_err_clear(stb[5]),
    .irq(irq)
  );

  initial begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end

  // clear strobes seen at the ports
  always @(posedge core_clk) if (rstn && stb !== 6'h00) stb_q.push_back(stb);

  task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task give_verdict;
    if (errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task tmo;
    chk("handshake", 34'h1, 34'h0);
    give_verdict;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    int k;
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready) break;
      bready <= (k > 1);
    end
    rs = bresp;
    bready <= 1'h0;
    if (k == 50) tmo();
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    araddr <= a;
    arvalid <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready) break;
      rready <= (k > 0);
    end
    v = rdata;
    rs = rresp;
    rready <= 1'h0;
    if (k == 50) tmo();
  endtask

  initial begin
    seed = 32'h3137A527;
    errors = 0;
    n_tests = 0;
    m_raw = 0;
    m_en = 0;
    rstn = 1'h0;
    {awaddr, araddr, wdata, wstrb, evt} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    ofs = '{`UIC_OFS_IRQ_ENABLE, `UIC_OFS_IRQ_RAW, `UIC_OFS_IRQ_MASKED, `UIC_OFS_IRQ_CLEAR,
            `UIC_OFS_IDENT_FOUR, `UIC_OFS_IDENT_FIVE, `UIC_OFS_IDENT_SIX};
    rv = '{32'h0, 32'h0, 32'h0, 32'h0, {24'h0, `UIC_IDENT_FOUR_DEF},
           {24'h0, `UIC_IDENT_FIVE_DEF}, {24'h0, `UIC_IDENT_SIX_DEF}};
    repeat (6) @(posedge core_clk);
    rstn <= 1'h1;
    @(posedge core_clk);
    // reset values, then identification bytes after a write attempt
    for (i = 0; i < 7; i++) begin
      rd(ofs[i], d, r);
      chk("reset read", {r, d}, {2'h0, rv[i]});
      if (i > 3) begin
        wr(ofs[i], 32'hFFFFFFFF, r);
        chk("ident write", r, `UIC_RESP_OKAY);
        rd(ofs[i], d, r);
        chk("ident after write", {r, d}, {2'h0, rv[i]});
      end
    end
    // unmapped accesses
    wr(12'h100, 32'hFFFFFFFF, r);
    chk("unmapped write", r, `UIC_RESP_SLVERR);
    rd(12'h102, d, r);
    chk("unmapped read", {r, d}, {`UIC_RESP_SLVERR, 32'h0});
    // random events, enables and clears against the model
    for (i = 0; i < 24; i++) begin
      if (i % 4 == 0) begin
        m_en = $random(seed) & 32'h3F0;
        wr(`UIC_OFS_IRQ_ENABLE, m_en, r);
      end
      evt <= 6'($random(seed));
      @(posedge core_clk);
      m_raw |= evt << 4;
      evt <= 6'h00;
      @(posedge core_clk);
      chk("irq set", irq, (m_raw & m_en) != 0);
      c = $random(seed);
      if (i == 1) c = 32'h0000000F;
      wr(`UIC_OFS_IRQ_CLEAR, c, r);
      m_raw &= ~(c & 32'h3F0);
      repeat (2) @(posedge core_clk);
      chk("strobe count", stb_q.size(), c[9:4] != 6'h00);
      chk("strobes", (stb_q.size() == 0) ? 6'h00 : stb_q.pop_front(),
          c[9:4]);
      stb_q.delete();
      rd(`UIC_OFS_IRQ_RAW, d, r);
      chk("raw", {r, d}, m_raw);
      rd(`UIC_OFS_IRQ_MASKED, d, r);
      chk("masked", {r, d}, m_raw & m_en);
      rd(`UIC_OFS_IRQ_CLEAR, d, r);
      chk("clear read", {r, d}, 34'h0);
      chk("irq after clear", irq, (m_raw & m_en) != 0);
    end
    give_verdict;
  end
endmodule

`default_nettype wire
